// ### rtl/tcsr_pkg.sv
package tcsr_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL_A_REG  = 8'h00;
	localparam logic [7:0] IDX_RDREQ  = 8'h02;
	localparam logic [7:0] IDX_BCLR   = 8'h04;
	localparam logic [7:0] IDX_BSET   = 8'h05;
	localparam logic [7:0] IDX_CHANNEL_CAPTURE_INVERT_CTRL  = 8'h06;
	localparam logic [7:0] IDX_DEBUG  = 8'h08;
	localparam logic [7:0] IDX_STATUS = 8'h0F;
	localparam logic [7:0] IDX_SNAP   = 8'h10;

	// control_a_reg fields
	localparam int SRST_BIT   = 0;
	localparam int ENABLE_BIT = 1;
	// read_sync_request fields
	localparam int READ_REQUEST_TRIGGER_BIT   = 15;
	localparam int CONTINUOUS_READ_ENABLE_BIT  = 14;
	localparam int RADDR_W    = 5;
	// control_b_state fields
	localparam int CMD_LSB     = 6;
	localparam int SINGLE_RUN_MODE_BIT = 2;
	localparam int DIR_BIT     = 0;
	// channel_capture_invert_ctrl fields
	localparam int CPTEN_LSB = 4;
	localparam int INVEN_LSB = 0;
	localparam int NUM_CH    = 2;
	// debug_halt_control and status fields
	localparam int RUN_DURING_DEBUG_BIT  = 0;
	localparam int STAT_SRST   = 0;
	localparam int STAT_BUSY   = 7;

	// read synchronisation targets
	localparam logic [4:0] TGT_COUNT = 5'h10;
	localparam logic [4:0] TGT_CC0   = 5'h18;
	localparam logic [4:0] TGT_CC1   = 5'h1A;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// clock-domain synchronisation delay in aclk cycles
	localparam logic [2:0] SYNC_CYCLES = 3'h4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CMD_NONE   = 2'h0,
		CMD_RETRIG = 2'h1,
		CMD_STOP   = 2'h2,
		CMD_RSVD   = 2'h3
	} tcsr_cmd_type;

	typedef enum logic [1:0] {
		SK_READ  = 2'h0,
		SK_CLR   = 2'h1,
		SK_SET   = 2'h2,
		SK_CHANNEL_CAPTURE_INVERT_CTRL = 2'h3
	} tcsr_kind_type;
endpackage

// ### rtl/tcsr_sync_delay.sv
`timescale 1ns/1ps
`default_nettype none
module tcsr_sync_delay (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic start,
	input  wire logic clear,
	output logic      busy,
	output logic      done
);
	typedef enum logic [1:0] {
		SD_IDLE = 2'b00,
		SD_RUN  = 2'b01,
		SD_DONE = 2'b11
	} tcsr_sd_state_type;

	tcsr_sd_state_type state_q;
	logic [2:0]        cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			state_q <= SD_IDLE;
			cnt_q   <= 3'h0;
		end else begin
			unique case (state_q)
				SD_IDLE: begin
					if (start) begin
						state_q <= SD_RUN;
						cnt_q   <= tcsr_pkg::SYNC_CYCLES - 3'h1;
					end
				end
				SD_RUN: begin
					if (cnt_q == 3'h0) begin
						state_q <= SD_DONE;
					end else begin
						cnt_q <= cnt_q - 3'h1;
					end
				end
				SD_DONE: begin
					state_q <= SD_IDLE;
				end
				default: begin
					state_q <= SD_IDLE;
				end
			endcase
		end
	end

	assign busy = (state_q != SD_IDLE);
	assign done = (state_q == SD_DONE);

	default clocking sd_cb @(posedge aclk); endclocking
	default disable iff (!aresetn || clear);

	a_busy_span: assert property ( // R3
		start && !busy |=> busy [*5] ##1 !busy
	) else $error("sync delay busy span wrong");
	a_done_end: assert property ( // R3
		done |=> !busy && !done
	) else $error("sync delay done not final");
endmodule // tcsr_sync_delay
`default_nettype wire

// ### rtl/tcsr_timer_control_sync_regs.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - soft reset clears registers except debug control, disables timer
// R2 - soft reset write discards other fields
// R3 - reset bit and busy clear together
// R4 - soft reset bit never enable locked
// R5 - read trigger syncs target, reads zero
// R6 - continuous mode resyncs on every update
// R7 - software triggers once after continuous set
// R8 - only count and channel targets valid
// R9 - both views share one control state
// R10 - command runs on next tick, clears
// R11 - command codes none, retrigger, stop, reserved
// R12 - clear view cancels, set view loads
// R13 - one-shot halts at next wrap
// R14 - one-shot set and clear views
// R15 - direction zero up, one down
// R16 - direction set and clear views
// R17 - views synchronised and write guarded
// R18 - capture enable selects capture per channel
// R19 - invert bit flips waveform output
// R20 - debug control survives soft reset
// R21 - software waits for busy before next
module tcsr_timer_control_sync_regs (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [9:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [9:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        write_guard_lock,
	input  wire logic        count_tick,
	input  wire logic        count_wrap,
	input  wire logic        value_update,
	input  wire logic [15:0] count_value,
	input  wire logic [15:0] cc0_value,
	input  wire logic [15:0] cc1_value,
	input  wire logic [1:0]  wave_raw,
	output logic             timer_enable,
	output logic             soft_reset_active,
	output logic             sync_busy_flag,
	output logic             counter_running,
	output logic             cmd_retrigger,
	output logic             cmd_stop,
	output logic             single_run_mode,
	output logic             count_down,
	output logic [1:0]       channel_capture_enable,
	output logic [1:0]       waveform_output_pin,
	output logic             run_during_debug
);
	logic                    aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
	logic [7:0]              widx_q, ridx_q;
	logic [31:0]             wdata_q, rdata_q, wmask, wd, rd_word;
	logic [3:0]              wstrb_q;
	logic [1:0]              bresp_q, rresp_q;
	logic                    do_write, do_read, w_err, wr_ok, rd_map;
	logic                    srst_start, srst_busy, srst_done;
	logic                    rs_start, rs_busy, rs_done;
	logic                    hit_a, hit_rq, hit_clr, hit_set, hit_c, hit_dbg;
	logic                    read_request_trigger_wr, continuous_read_enable_d, bus_sync, cont_sync;
	logic [4:0]              raddr_d;
	logic [7:0]              pend_d, pend_q;
	tcsr_pkg::tcsr_kind_type kind_d, kind_q;
	tcsr_pkg::tcsr_cmd_type  cmd_q;
	logic                    enable_q, continuous_read_enable_q, armed_q, single_run_mode_q, dir_q;
	logic [4:0]              raddr_q;
	logic [1:0]              cpten_q, inven_q, wave_q;
	logic                    run_during_debug_q, run_q, retrig_q, stop_q;
	logic [15:0]             snap_q;
	logic                    exec_rt, exec_sp;

	function automatic logic valid_tgt(input logic [4:0] a);
		return (a == tcsr_pkg::TGT_COUNT) || (a == tcsr_pkg::TGT_CC0) ||
		       (a == tcsr_pkg::TGT_CC1); // R8
	endfunction

	// byte lanes of the write strobe
	genvar gb;
	for (gb = 0; gb < 4; gb++) begin : g_lane
		assign wmask[8*gb +: 8] = {8{wstrb_q[gb]}};
	end
	assign wd = wdata_q & wmask;

	// AXI4-Lite write address and data, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_q <= 1'b0;
			widx_q  <= tcsr_pkg::RST_BYTE;
		end else if (awvalid && !aw_ok_q) begin
			aw_ok_q <= 1'b1;
			widx_q  <= awaddr[9:2];
		end else if (do_write) begin
			aw_ok_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_ok_q  <= 1'b0;
			wdata_q <= tcsr_pkg::RST_WORD;
			wstrb_q <= 4'h0;
		end else if (wvalid && !w_ok_q) begin
			w_ok_q  <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end else if (do_write) begin
			w_ok_q <= 1'b0;
		end
	end

	assign awready  = !aw_ok_q;
	assign wready   = !w_ok_q;
	assign do_write = aw_ok_q && w_ok_q && !bvalid_q;

	// unmapped words and guarded writes under lock answer SLVERR
	always_comb begin
		w_err = 1'b0;
		case (widx_q)
			tcsr_pkg::IDX_CONTROL_A_REG, tcsr_pkg::IDX_RDREQ,
			tcsr_pkg::IDX_STATUS, tcsr_pkg::IDX_SNAP: w_err = 1'b0;
			tcsr_pkg::IDX_BCLR, tcsr_pkg::IDX_BSET, tcsr_pkg::IDX_CHANNEL_CAPTURE_INVERT_CTRL,
			tcsr_pkg::IDX_DEBUG: w_err = write_guard_lock; // R17
			default: w_err = 1'b1;
		endcase
	end

	// while a soft reset runs only the debug word still takes writes
	assign wr_ok   = do_write && !w_err;
	assign hit_a   = wr_ok && !srst_busy && widx_q == tcsr_pkg::IDX_CONTROL_A_REG;
	assign hit_rq  = wr_ok && !srst_busy && widx_q == tcsr_pkg::IDX_RDREQ;
	assign hit_clr = wr_ok && !srst_busy && widx_q == tcsr_pkg::IDX_BCLR;
	assign hit_set = wr_ok && !srst_busy && widx_q == tcsr_pkg::IDX_BSET;
	assign hit_c   = wr_ok && !srst_busy && widx_q == tcsr_pkg::IDX_CHANNEL_CAPTURE_INVERT_CTRL;
	assign hit_dbg = wr_ok && widx_q == tcsr_pkg::IDX_DEBUG;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= tcsr_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= w_err ? tcsr_pkg::RESP_SLVERR : tcsr_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;

	// soft reset: not gated by enable, other fields dropped
	assign srst_start = hit_a && wd[tcsr_pkg::SRST_BIT]; // R4

	tcsr_sync_delay u_srst_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (srst_start),
		.clear   (1'b0),
		.busy    (srst_busy),
		.done    (srst_done)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			enable_q <= 1'b0; // R1
		end else if (hit_a && !wd[tcsr_pkg::SRST_BIT] &&
		             wmask[tcsr_pkg::ENABLE_BIT]) begin
			enable_q <= wd[tcsr_pkg::ENABLE_BIT]; // R2
		end
	end

	// read request fields and synchronisation starts
	assign continuous_read_enable_d = wmask[tcsr_pkg::CONTINUOUS_READ_ENABLE_BIT] ? wd[tcsr_pkg::CONTINUOUS_READ_ENABLE_BIT]
	                                            : continuous_read_enable_q;
	assign raddr_d = (raddr_q & ~wmask[4:0]) | wd[4:0];
	assign read_request_trigger_wr = hit_rq && wd[tcsr_pkg::READ_REQUEST_TRIGGER_BIT];
	// the trigger is armed, not stored, so it always reads zero
	assign bus_sync = (read_request_trigger_wr && valid_tgt(raddr_d)) || hit_clr ||
	                  hit_set || hit_c; // R5 R17
	assign cont_sync = continuous_read_enable_q && armed_q && value_update &&
	                   valid_tgt(raddr_q); // R6
	// a sync request while busy is dropped; software must wait
	assign rs_start = !rs_busy && (bus_sync || cont_sync); // R21

	always_comb begin
		kind_d = tcsr_pkg::SK_READ;
		pend_d = wd[7:0];
		if (hit_clr) begin
			kind_d = tcsr_pkg::SK_CLR;
		end else if (hit_set) begin
			kind_d = tcsr_pkg::SK_SET;
		end else if (hit_c) begin
			kind_d = tcsr_pkg::SK_CHANNEL_CAPTURE_INVERT_CTRL;
			pend_d = ({2'b00, cpten_q, 2'b00, inven_q} & ~wmask[7:0]) |
			         wd[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			continuous_read_enable_q <= 1'b0;
			armed_q <= 1'b0;
			raddr_q <= 5'h00;
		end else if (hit_rq) begin
			continuous_read_enable_q <= continuous_read_enable_d;
			armed_q <= continuous_read_enable_d && (armed_q || read_request_trigger_wr); // R6 R7
			raddr_q <= raddr_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			kind_q <= tcsr_pkg::SK_READ;
			pend_q <= tcsr_pkg::RST_BYTE;
		end else if (rs_start) begin
			kind_q <= kind_d;
			pend_q <= pend_d;
		end
	end

	tcsr_sync_delay u_reg_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (rs_start),
		.clear   (srst_done),
		.busy    (rs_busy),
		.done    (rs_done)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			snap_q <= tcsr_pkg::RST_HALF;
		end else if (rs_done && kind_q == tcsr_pkg::SK_READ) begin
			case (raddr_q) // R5 R8
				tcsr_pkg::TGT_CC0: snap_q <= cc0_value;
				tcsr_pkg::TGT_CC1: snap_q <= cc1_value;
				default:           snap_q <= count_value;
			endcase
		end
	end

	// shared control-B state behind both views
	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			single_run_mode_q <= 1'b0;
			dir_q     <= 1'b0;
		end else if (rs_done && kind_q == tcsr_pkg::SK_SET) begin
			single_run_mode_q <= single_run_mode_q | pend_q[tcsr_pkg::SINGLE_RUN_MODE_BIT]; // R9 R14
			dir_q     <= dir_q | pend_q[tcsr_pkg::DIR_BIT]; // R16
		end else if (rs_done && kind_q == tcsr_pkg::SK_CLR) begin
			single_run_mode_q <= single_run_mode_q & ~pend_q[tcsr_pkg::SINGLE_RUN_MODE_BIT]; // R14
			dir_q     <= dir_q & ~pend_q[tcsr_pkg::DIR_BIT]; // R16
		end
	end

	assign exec_rt = count_tick && cmd_q == tcsr_pkg::CMD_RETRIG; // R11
	assign exec_sp = count_tick && cmd_q == tcsr_pkg::CMD_STOP; // R11

	// a new command landing on an execute tick replaces the old one
	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			cmd_q <= tcsr_pkg::CMD_NONE;
		end else if (rs_done && pend_q[7:6] != 2'b00 &&
		             kind_q == tcsr_pkg::SK_SET) begin
			cmd_q <= tcsr_pkg::tcsr_cmd_type'(pend_q[7:6]); // R12
		end else if (rs_done && pend_q[7:6] != 2'b00 &&
		             kind_q == tcsr_pkg::SK_CLR) begin
			cmd_q <= tcsr_pkg::CMD_NONE; // R12
		end else if (count_tick) begin
			cmd_q <= tcsr_pkg::CMD_NONE; // R10
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			retrig_q <= 1'b0;
			stop_q   <= 1'b0;
		end else begin
			retrig_q <= exec_rt; // R10
			stop_q   <= exec_sp; // R10
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			run_q <= 1'b0;
		end else if (!enable_q || exec_sp) begin
			run_q <= 1'b0;
		end else if (exec_rt) begin
			run_q <= 1'b1;
		end else if (count_wrap && single_run_mode_q) begin
			run_q <= 1'b0; // R13
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || srst_done) begin
			cpten_q <= 2'b00;
			inven_q <= 2'b00;
		end else if (rs_done && kind_q == tcsr_pkg::SK_CHANNEL_CAPTURE_INVERT_CTRL) begin
			cpten_q <= pend_q[tcsr_pkg::CPTEN_LSB +: 2]; // R18
			inven_q <= pend_q[tcsr_pkg::INVEN_LSB +: 2]; // R19
		end
	end

	// only power-on reset touches the debug control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_during_debug_q <= 1'b0;
		end else if (hit_dbg && wmask[tcsr_pkg::RUN_DURING_DEBUG_BIT]) begin
			run_during_debug_q <= wd[tcsr_pkg::RUN_DURING_DEBUG_BIT]; // R20
		end
	end

	genvar gc;
	for (gc = 0; gc < tcsr_pkg::NUM_CH; gc++) begin : g_wave
		always_ff @(posedge aclk) begin
			if (!aresetn || srst_done) begin
				wave_q[gc] <= 1'b0;
			end else begin
				wave_q[gc] <= wave_raw[gc] ^ inven_q[gc]; // R19
			end
		end
	end

	// read side
	always_comb begin
		rd_word = tcsr_pkg::RST_WORD;
		rd_map  = 1'b1;
		case (araddr[9:2])
			tcsr_pkg::IDX_CONTROL_A_REG: begin
				rd_word[tcsr_pkg::SRST_BIT]   = srst_busy; // R3
				rd_word[tcsr_pkg::ENABLE_BIT] = enable_q;
			end
			tcsr_pkg::IDX_RDREQ: begin
				rd_word[tcsr_pkg::CONTINUOUS_READ_ENABLE_BIT] = continuous_read_enable_q;
				rd_word[4:0]                 = raddr_q;
			end
			tcsr_pkg::IDX_BCLR, tcsr_pkg::IDX_BSET: begin
				rd_word[7:0] = {cmd_q, 3'b000, single_run_mode_q, 1'b0, dir_q}; // R9
			end
			tcsr_pkg::IDX_CHANNEL_CAPTURE_INVERT_CTRL: begin
				rd_word[7:0] = {2'b00, cpten_q, 2'b00, inven_q};
			end
			tcsr_pkg::IDX_DEBUG: begin
				rd_word[tcsr_pkg::RUN_DURING_DEBUG_BIT] = run_during_debug_q;
			end
			tcsr_pkg::IDX_STATUS: begin
				rd_word[tcsr_pkg::STAT_SRST] = srst_busy; // R3
				rd_word[tcsr_pkg::STAT_BUSY] = srst_busy || rs_busy; // R3
			end
			tcsr_pkg::IDX_SNAP: begin
				rd_word[15:0] = snap_q;
			end
			default: begin
				rd_map = 1'b0;
			end
		endcase
	end

	assign do_read = arvalid && !rvalid_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= tcsr_pkg::RST_WORD;
			rresp_q  <= tcsr_pkg::RESP_OKAY;
			ridx_q   <= tcsr_pkg::RST_BYTE;
		end else if (do_read) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_map ? tcsr_pkg::RESP_OKAY : tcsr_pkg::RESP_SLVERR;
			ridx_q   <= araddr[9:2];
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign arready                = !rvalid_q;
	assign rvalid                 = rvalid_q;
	assign rdata                  = rdata_q;
	assign rresp                  = rresp_q;
	assign timer_enable           = enable_q;
	assign soft_reset_active      = srst_busy;
	assign sync_busy_flag         = srst_busy || rs_busy;
	assign counter_running        = run_q;
	assign cmd_retrigger          = retrig_q;
	assign cmd_stop               = stop_q;
	assign single_run_mode        = single_run_mode_q; // R13
	assign count_down             = dir_q; // R15
	assign channel_capture_enable = cpten_q; // R18
	assign waveform_output_pin    = wave_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_srst_clears: assert property ( // R1
		srst_done |=> !enable_q && cmd_q == tcsr_pkg::CMD_NONE &&
		              cpten_q == 2'b00 && !continuous_read_enable_q
	) else $error("soft reset left state");
	a_srst_discard: assert property ( // R2
		srst_start |=> enable_q == $past(enable_q)
	) else $error("soft reset write changed enable");
	a_srst_busy: assert property ( // R3
		srst_start |=> (soft_reset_active && sync_busy_flag) [*5]
		##1 !soft_reset_active
	) else $error("soft reset busy span wrong");
	a_read_request_trigger_zero: assert property ( // R5
		rvalid_q && ridx_q == tcsr_pkg::IDX_RDREQ |-> !rdata_q[15]
	) else $error("trigger bit read as one");
	a_cmd_stop: assert property ( // R10
		exec_sp && !rs_done && !srst_done |=>
		cmd_stop && cmd_q == tcsr_pkg::CMD_NONE
	) else $error("stop command not executed");
	a_cmd_code: assert property ( // R11
		cmd_retrigger |-> $past(cmd_q) == tcsr_pkg::CMD_RETRIG
	) else $error("retrigger without its code");
	a_clr_cancel: assert property ( // R12
		rs_done && kind_q == tcsr_pkg::SK_CLR && pend_q[7:6] != 2'b00 &&
		!srst_done |=> cmd_q == tcsr_pkg::CMD_NONE
	) else $error("clear view left command");
	a_single_run_mode_halt: assert property ( // R13
		count_wrap && single_run_mode_q && !exec_rt && !srst_done |=> !run_q
	) else $error("one-shot did not halt");
	a_dir_set: assert property ( // R16
		rs_done && kind_q == tcsr_pkg::SK_SET && pend_q[0] &&
		!srst_done |=> count_down
	) else $error("set view did not count down");
	a_guard_err: assert property ( // R17
		do_write && write_guard_lock && widx_q == tcsr_pkg::IDX_CHANNEL_CAPTURE_INVERT_CTRL
		|=> bresp == tcsr_pkg::RESP_SLVERR && $stable(inven_q)
	) else $error("guarded write not refused");
	a_wave_inv: assert property ( // R19
		$past(aresetn) && !$past(srst_done) |-> waveform_output_pin ==
		($past(wave_raw) ^ $past(inven_q))
	) else $error("waveform inversion wrong");
	a_dbg_keep: assert property ( // R20
		srst_done && !hit_dbg |=> run_during_debug == $past(run_during_debug_q)
	) else $error("debug control lost at soft reset");

	c_read_sync: cover property (read_request_trigger_wr ##[1:10] rs_done);
	c_cont_sync: cover property (cont_sync && rs_start);
	c_soft_reset: cover property (srst_start ##[1:10] srst_done);
	c_single_run_mode: cover property (run_q && single_run_mode_q && count_wrap);

	assign run_during_debug = run_during_debug_q;
endmodule // tcsr_timer_control_sync_regs
`default_nettype wire

// ### verif/tcsr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [9:0]  awaddr = '0, araddr = '0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = '0, rdata, v;
	logic [3:0]  wstrb = '0;
	logic [1:0]  bresp, rresp, channel_capture_enable, waveform_output_pin;
	logic [1:0]  wave_raw = '0;
	logic        awready, wready, bvalid, arready, rvalid, sb;
	logic        write_guard_lock = 1'h0, count_tick = 1'h0;
	logic        count_wrap = 1'h0, value_update = 1'h0;
	logic [15:0] count_value = '0, cc0_value = '0, cc1_value = '0;
	logic        timer_enable, soft_reset_active, sync_busy_flag;
	logic        counter_running, cmd_retrigger, cmd_stop;
	logic        single_run_mode, count_down, run_during_debug;
	logic [2:0]  nr, ns;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          error_cnt = 0;
	int          checks = 0;
	logic [31:0] seed = 32'h0000_C1D7;

	always #25 aclk = ~aclk;

	tcsr_timer_control_sync_regs DUT (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .write_guard_lock,
		.count_tick, .count_wrap, .value_update, .count_value, .cc0_value,
		.cc1_value, .wave_raw, .timer_enable, .soft_reset_active,
		.sync_busy_flag, .counter_running, .cmd_retrigger, .cmd_stop,
		.single_run_mode, .count_down, .channel_capture_enable,
		.waveform_output_pin, .run_during_debug
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// responses are compared where they appear, against the oldest note
	always @(negedge aclk) begin
		if (bvalid && bready)
			chk(bresp, bq.pop_front());
		if (rvalid && rready)
			chk({rresp, rdata}, rq.pop_front());
	end

	// ready is sampled at the falling edge; outputs only move after rising
	task automatic wr(input logic [7:0] i, input logic [31:0] d,
		input logic [1:0] e);
		logic a, w, b;
		bq.push_back(e);
		@(posedge aclk);
		awaddr <= {i, 2'h0};
		wdata <= d;
		wstrb <= 4'hF;
		{awvalid, wvalid, bready} <= 3'h7;
		b = 1'h0;
		while (!b) begin
			@(negedge aclk);
			a = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			@(posedge aclk);
			if (a) awvalid <= 1'h0;
			if (w) wvalid <= 1'h0;
			if (b) bready <= 1'h0;
		end
	endtask

	task automatic rd(input logic [7:0] i, input logic [33:0] e);
		logic a, r;
		rq.push_back(e);
		@(posedge aclk);
		araddr <= {i, 2'h0};
		{arvalid, rready} <= 2'h3;
		r = 1'h0;
		while (!r) begin
			@(negedge aclk);
			a = arvalid && arready;
			r = rvalid && rready;
			@(posedge aclk);
			if (a) arvalid <= 1'h0;
			if (r) rready <= 1'h0;
		end
	endtask

	task automatic wb();
		int n;
		sb = 1'h0;
		n = 0;
		do begin
			@(negedge aclk);
			sb |= sync_busy_flag;
			n++;
		end while ((sync_busy_flag || n < 3) && n < 40);
		if (n >= 40)
			chk(1, 0);
	endtask

	task automatic ws(input logic [7:0] i, input logic [31:0] d);
		wr(i, d, 2'h0);
		wb();
	endtask

	task automatic pt(input logic t, input logic w);
		@(posedge aclk);
		count_tick <= t;
		count_wrap <= w;
		@(posedge aclk);
		count_tick <= 1'h0;
		count_wrap <= 1'h0;
		nr = '0;
		ns = '0;
		repeat (4) begin
			@(negedge aclk);
			nr += cmd_retrigger;
			ns += cmd_stop;
		end
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		rd(8'h02, '0);
		rd(8'h04, '0);
		rd(8'h06, '0);
		rd(8'h03, {2'h2, 32'h0});
		wr(8'h03, 32'h1, 2'h2);
		$display("reset test done");
		ws(8'h05, 32'h5);
		rd(8'h04, 34'h5);
		chk({single_run_mode, count_down}, 2'h3);
		ws(8'h04, 32'h1);
		rd(8'h05, 34'h4);
		chk(count_down, 1'h0);
		ws(8'h05, 32'h0);
		rd(8'h05, 34'h4);
		ws(8'h00, 32'h2);
		chk(timer_enable, 1'h1);
		// each non-zero command code, including the reserved one
		for (int c = 1; c < 4; c++) begin
			ws(8'h05, c << 6);
			rd(8'h04, (c << 6) | 4);
			pt(1'h1, 1'h0);
			chk({nr, ns}, {3'(c == 1), 3'(c == 2)});
			chk(counter_running, c == 1);
			rd(8'h04, 34'h4);
		end
		ws(8'h05, 32'h40);
		ws(8'h04, 32'hC0);
		pt(1'h1, 1'h0);
		chk({nr, ns}, '0);
		$display("command test done");
		ws(8'h05, 32'h40);
		pt(1'h1, 1'h0);
		pt(1'h0, 1'h1);
		chk(counter_running, 1'h0);
		ws(8'h04, 32'h4);
		ws(8'h05, 32'h40);
		pt(1'h1, 1'h0);
		pt(1'h0, 1'h1);
		chk(counter_running, 1'h1);
		@(posedge aclk);
		write_guard_lock <= 1'h1;
		wr(8'h06, 32'h33, 2'h2);
		rd(8'h06, '0);
		write_guard_lock <= 1'h0;
		repeat (4) begin
			v = rnd() & 32'h33;
			ws(8'h06, v);
			rd(8'h06, v);
			chk(channel_capture_enable, v[5:4]);
			sb = 1'(rnd());
			wave_raw <= v[1:0] ^ {sb, ~sb};
			repeat (3) @(negedge aclk);
			chk(waveform_output_pin, wave_raw ^ v[1:0]);
		end
		$display("channel test done");
		v = rnd();
		@(posedge aclk);
		count_value <= v[15:0];
		ws(8'h02, 32'h8010);
		chk(sb, 1'h1);
		rd(8'h10, v[15:0]);
		rd(8'h02, 34'h10);
		ws(8'h02, 32'h8005);
		chk(sb, 1'h0);
		ws(8'h02, 32'hC018);
		v = rnd();
		@(posedge aclk);
		cc0_value <= v[15:0];
		value_update <= 1'h1;
		@(posedge aclk);
		value_update <= 1'h0;
		wb();
		chk(sb, 1'h1);
		rd(8'h10, v[15:0]);
		rd(8'h02, 34'h4018);
		ws(8'h02, 32'h0);
		$display("read sync test done");
		// one-shot and direction set, so the soft reset has work to undo
		ws(8'h05, 32'h5);
		rd(8'h04, 34'h5);
		ws(8'h08, 32'h1);
		wr(8'h00, 32'h3, 2'h0);
		@(negedge aclk);
		chk({soft_reset_active, sync_busy_flag}, 2'h3);
		// both flags must fall on the same edge
		for (int n = 0; n < 20 && soft_reset_active; n++) begin
			chk(sync_busy_flag, 1'h1);
			@(negedge aclk);
		end
		chk({soft_reset_active, sync_busy_flag}, 2'h0);
		chk({timer_enable, counter_running}, 2'h0);
		rd(8'h00, '0);
		rd(8'h04, '0);
		rd(8'h06, '0);
		rd(8'h08, 34'h1);
		chk(run_during_debug, 1'h1);
		$display("soft reset test done");
		end_sim();
	end

	// whole run is a few hundred cycles; this is ample margin
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		$display("ERROR %0t: timeout", $time);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
